//--- core/fvm_pkg.sv
// Package of constants and types for the flash and video-light mode controller
package fvm_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] TIMER_OFS  = 8'h04;
  localparam logic [7:0] VOLT_OFS   = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;

  // Control register fields
  localparam int MODE_LSB     = 0;
  localparam int FVR_BIT      = 2;
  localparam int TTYPE_BIT    = 3;
  localparam int SFS_BIT      = 4;
  localparam int PTYPE_BIT    = 5;
  localparam int VCUR_LSB     = 8;
  // Timer register fields
  localparam int TDUR_LSB     = 0;
  localparam int TRANGE_BIT   = 3;
  // Status register fields
  localparam int ST_EXP_BIT   = 0;
  localparam int ST_PG_BIT    = 1;
  localparam int ST_FL_BIT    = 2;
  localparam int ST_VL_BIT    = 3;
  localparam int ST_CONV_BIT  = 4;
  localparam int ST_WD_BIT    = 5;

  // Reset values
  localparam logic [1:0] MODE_RST  = 2'h0;
  localparam logic [2:0] VCUR_RST  = 3'h0;
  localparam logic [2:0] TDUR_RST  = 3'h0;
  localparam logic [3:0] VOLT_RST  = 4'h0;

  // Mode encodings
  localparam logic [1:0] MODE_SHDN  = 2'h0;
  localparam logic [1:0] MODE_VIDEO = 2'h1;
  localparam logic [1:0] MODE_FLASH = 2'h2;
  localparam logic [1:0] MODE_VOLT  = 2'h3;

  // Output voltage mapping in millivolts
  localparam int VOUT_MIN_MV  = 3825;
  localparam int VOUT_STEP_MV = 125;

  // Timing
  localparam longint CLK_HZ         = 25000000;
  localparam longint WD_TIMEOUT_MS  = 13000;
  localparam longint WD_CYCLES      = WD_TIMEOUT_MS * CLK_HZ / 1000;
  // Flash timer base units in microseconds, short and long range
  localparam longint FT_UNIT_SHORT_US = 1000;
  localparam longint FT_UNIT_LONG_US  = 8000;
  localparam longint FT_SHORT_CYC     = FT_UNIT_SHORT_US * CLK_HZ / 1000000;
  localparam longint FT_LONG_CYC      = FT_UNIT_LONG_US * CLK_HZ / 1000000;

  // Control register fields as one carrier
  typedef struct packed {
    logic [2:0] vcur;
    logic       ptype;
    logic       sfs;
    logic       ttype;
    logic       fvr;
    logic [1:0] mode;
  } fvm_ctrl_s;

  typedef enum logic [2:0] {
    FL_IDLE  = 3'b001,
    FL_LEVEL = 3'b010,
    FL_EDGE  = 3'b100
  } fvm_flash_e;

endpackage : fvm_pkg

//--- core/fvm_timer.sv
// Loadable down counter used for the flash and watchdog timers
`timescale 1ns/1ns
`default_nettype none
module fvm_timer #(
  parameter int W = 32
) (
  input  wire logic         clk,     // System clock
  input  wire logic         sys_rst, // Async reset, active high
  input  wire logic         load,    // Load and start
  input  wire logic [W-1:0] value,   // Cycles to run
  input  wire logic         stop,    // Abort count
  output logic              running, // Counting
  output logic              expire   // One-cycle pulse at end
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q   <= '0;
      running <= 1'b0;
      expire  <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (load) begin
        cnt_q   <= value;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running) begin
        if (cnt_q <= W'(1)) begin
          running <= 1'b0;
          expire  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end

endmodule // fvm_timer
`default_nettype wire

//--- core/fvm_ctrl.sv
// Mode, trigger, timer and power-good control of the flash driver
// Function
// RULE1: Flash triggers from strobe pins or software; edge or level style.
// RULE2: Edge or software start sets flash length from programmed timer.
// RULE3: Level trigger: timer is maximum on-time, ends flash while strobe high.
// RULE4: Mode 01 ignores strobes and software start, runs video light steadily.
// RULE5: Video mode, select low: mode rewrite needed within 13 s or shutdown.
// RULE6: Select input high disables the video watchdog.
// RULE7: Mode 10 enables strobes, software start, flash timer; no watchdog.
// RULE8: Strobe mode switches LEDs as the strobe inputs direct.
// RULE9: Select high picks video, low picks flash; trigger fires it.
// RULE10: Trigger type 0 is level sensitive, 1 is rising edge.
// RULE11: Level flash starts on rising edge, stops on low or expiry flag.
// RULE12: Edge flash starts on strobe rise or software start 0 to 1.
// RULE13: Running edge flash ignores all triggers, ends only at expiry; code also ends it on leaving mode 10.
// RULE14: Expiry clears the software start bit.
// RULE15: Mode 11 is fixed-voltage boost from code, LED sinks off.
// RULE16: Force bit regulates voltage in every mode; LED use per mode.
// RULE17: Mode 00 without force is shutdown: converter and LEDs off.
// RULE18: Power good active only in mode 11 or force; otherwise not-good.
// RULE19: Shutdown pin: ground for type 0, released for type 1.
// RULE20: Push-pull follows in-regulation flag; open-drain pulls low when set.
// RULE21: In-regulation only while output within -1.5% to +2.5% of target.
// RULE22: In-regulation drops while energy is returned toward lower target.
// RULE23: Voltage code maps linearly; mode writes restart the watchdog.
`timescale 1ns/1ns
`default_nettype none
module fvm_ctrl #(
  parameter longint WD_CYC    = fvm_pkg::WD_CYCLES,
  parameter longint FT_SHORT  = fvm_pkg::FT_SHORT_CYC,
  parameter longint FT_LONG   = fvm_pkg::FT_LONG_CYC
) (
  input  wire logic        clk,              // System clock
  input  wire logic        sys_rst,          // Async reset, active high
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB enable
  input  wire logic        pwrite,           // APB write
  input  wire logic [7:0]  paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  output logic [31:0]      prdata,           // APB read data
  output logic             pready,           // APB ready
  output logic             pslverr,          // APB error
  input  wire logic        strobe_trigger_input, // Strobe trigger pin
  input  wire logic        strobe_select_input,  // Video/flash select pin
  input  wire logic        vout_in_window,   // Analog: output within window
  input  wire logic        vout_falling,     // Analog: energy return active
  output logic             flash_on,         // Flash current enable
  output logic             video_on,         // Video current enable
  output logic [2:0]       video_current_setting, // Video current code
  output logic             conv_vreg,        // Converter in voltage mode
  output logic [12:0]      vout_target_mv,   // Target output in mV
  output logic             status_out,       // Status pin output
  output logic             status_oe         // Status pin output enable
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  fvm_pkg::fvm_ctrl_s ctrl_q;
  logic [2:0]  flash_timer_duration;
  logic        flash_timer_range_select;
  logic [3:0]  output_voltage_code;
  logic        expiry_flag;
  logic        wd_tripped_q;
  logic        output_in_regulation;
  logic        wr_en, rd_en, addr_ok, mode_wr, sfs_rise, flash_expire;

  assign wr_en   = psel && penable && pwrite;
  // Read data is captured in the setup cycle so that it stands through the access phase
  assign rd_en   = psel && !penable && !pwrite;
  assign addr_ok = (paddr == fvm_pkg::CTRL_OFS) || (paddr == fvm_pkg::TIMER_OFS) ||
                   (paddr == fvm_pkg::VOLT_OFS) || (paddr == fvm_pkg::STATUS_OFS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign mode_wr = wr_en && (paddr == fvm_pkg::CTRL_OFS);
  // Software start edge only from a write that turns the bit on
  assign sfs_rise = mode_wr && pwdata[fvm_pkg::SFS_BIT] && !ctrl_q.sfs;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= '{vcur: fvm_pkg::VCUR_RST, ptype: 1'b0, sfs: 1'b0, ttype: 1'b0,
                  fvr: 1'b0, mode: fvm_pkg::MODE_RST};
    end else begin
      if (mode_wr) begin
        ctrl_q.mode  <= pwdata[fvm_pkg::MODE_LSB +: 2];
        ctrl_q.fvr   <= pwdata[fvm_pkg::FVR_BIT];
        ctrl_q.ttype <= pwdata[fvm_pkg::TTYPE_BIT];
        ctrl_q.ptype <= pwdata[fvm_pkg::PTYPE_BIT];
        ctrl_q.vcur  <= pwdata[fvm_pkg::VCUR_LSB +: 3];
        ctrl_q.sfs   <= pwdata[fvm_pkg::SFS_BIT];
      end
      // RULE14: expiry clears start
      if (flash_expire)
        ctrl_q.sfs <= 1'b0;
      // RULE5: watchdog shutdown
      if (wd_tripped_q && !mode_wr)
        ctrl_q.mode <= fvm_pkg::MODE_SHDN;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_timer_duration     <= fvm_pkg::TDUR_RST;
      flash_timer_range_select <= 1'b0;
      output_voltage_code      <= fvm_pkg::VOLT_RST;
    end else if (wr_en) begin
      if (paddr == fvm_pkg::TIMER_OFS) begin
        flash_timer_duration     <= pwdata[fvm_pkg::TDUR_LSB +: 3];
        flash_timer_range_select <= pwdata[fvm_pkg::TRANGE_BIT];
      end
      if (paddr == fvm_pkg::VOLT_OFS)
        output_voltage_code <= pwdata[3:0];
    end
  end

  // Expiry flag: set wins over clear (write 1 to status bit clears)
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      expiry_flag <= 1'b0;
    else if (flash_expire)
      expiry_flag <= 1'b1;
    else if (wr_en && paddr == fvm_pkg::STATUS_OFS && pwdata[fvm_pkg::ST_EXP_BIT])
      expiry_flag <= 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        fvm_pkg::CTRL_OFS: begin
          prdata[fvm_pkg::MODE_LSB +: 2] <= ctrl_q.mode;
          prdata[fvm_pkg::FVR_BIT]       <= ctrl_q.fvr;
          prdata[fvm_pkg::TTYPE_BIT]     <= ctrl_q.ttype;
          prdata[fvm_pkg::SFS_BIT]       <= ctrl_q.sfs;
          prdata[fvm_pkg::PTYPE_BIT]     <= ctrl_q.ptype;
          prdata[fvm_pkg::VCUR_LSB +: 3] <= ctrl_q.vcur;
        end
        fvm_pkg::TIMER_OFS: begin
          prdata[fvm_pkg::TDUR_LSB +: 3] <= flash_timer_duration;
          prdata[fvm_pkg::TRANGE_BIT]    <= flash_timer_range_select;
        end
        fvm_pkg::VOLT_OFS: prdata[3:0] <= output_voltage_code;
        fvm_pkg::STATUS_OFS: begin
          prdata[fvm_pkg::ST_EXP_BIT]  <= expiry_flag;
          prdata[fvm_pkg::ST_PG_BIT]   <= output_in_regulation;
          prdata[fvm_pkg::ST_FL_BIT]   <= flash_on;
          prdata[fvm_pkg::ST_VL_BIT]   <= video_on;
          prdata[fvm_pkg::ST_CONV_BIT] <= conv_vreg;
          prdata[fvm_pkg::ST_WD_BIT]   <= wd_tripped_q;
        end
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flash sequencing
  fvm_pkg::fvm_flash_e fl_q;
  logic        trig_q, trig_rise, strobe_mode, flash_sel, ft_running;
  logic [31:0] ft_load_val;

  // RULE7: strobes live only in mode 10
  assign strobe_mode = (ctrl_q.mode == fvm_pkg::MODE_FLASH);
  // RULE9: select low picks flash
  assign flash_sel   = strobe_mode && !strobe_select_input;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      trig_q <= 1'b0;
    else
      trig_q <= strobe_trigger_input;
  end
  assign trig_rise = strobe_trigger_input && !trig_q;

  // RULE2: duration from code and range, a zero code still gives one unit
  assign ft_load_val = 32'((64'(flash_timer_duration) + 64'd1) *
                       (flash_timer_range_select ? 64'(FT_LONG) : 64'(FT_SHORT)));

  logic start_level, start_edge, level_stop;
  // RULE1: edge and level styles
  // RULE10: trigger type picks level or edge
  // RULE11: level flash starts on rise
  assign start_level = (fl_q == fvm_pkg::FL_IDLE) && flash_sel && !ctrl_q.ttype && trig_rise;
  // RULE12: strobe rise or software start
  assign start_edge  = (fl_q == fvm_pkg::FL_IDLE) && strobe_mode && ctrl_q.ttype &&
                       ((flash_sel && trig_rise) || sfs_rise);
  // RULE11: strobe low or leaving flash mode stops it
  assign level_stop  = (fl_q == fvm_pkg::FL_LEVEL) && (!strobe_trigger_input || !flash_sel);

  fvm_timer #(.W(32)) u_flash_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (start_level || start_edge || (sfs_rise && strobe_mode && !ctrl_q.ttype &&
              fl_q == fvm_pkg::FL_IDLE)),
    .value   (ft_load_val),
    .stop    (level_stop || !strobe_mode),
    .running (ft_running),
    .expire  (flash_expire)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fl_q <= fvm_pkg::FL_IDLE;
    end else begin
      unique case (fl_q)
        fvm_pkg::FL_IDLE: begin
          if (start_edge || (sfs_rise && strobe_mode))
            fl_q <= fvm_pkg::FL_EDGE;
          else if (start_level)
            fl_q <= fvm_pkg::FL_LEVEL;
        end
        // RULE3: timer caps level flash
        fvm_pkg::FL_LEVEL: if (level_stop || flash_expire) fl_q <= fvm_pkg::FL_IDLE;
        // RULE13: expiry or leaving mode 10 ends edge flash
        fvm_pkg::FL_EDGE:  if (flash_expire || !strobe_mode) fl_q <= fvm_pkg::FL_IDLE;
        default:  fl_q <= fvm_pkg::FL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Video watchdog
  logic wd_armed, wd_expire, wd_running;
  // RULE6: select high disables watchdog
  assign wd_armed = (ctrl_q.mode == fvm_pkg::MODE_VIDEO) && !strobe_select_input;

  // RULE23: every mode write restarts count
  fvm_timer #(.W(40)) u_wd_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (mode_wr || (wd_armed && !wd_running && !wd_tripped_q)),
    .value   (40'(WD_CYC)),
    .stop    (!wd_armed),
    .running (wd_running),
    .expire  (wd_expire)
  );

  // Trip is held one cycle so the control register takes the shutdown
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      wd_tripped_q <= 1'b0;
    else
      wd_tripped_q <= wd_expire && wd_armed && !mode_wr;
  end

  ////////////////////////////////////////////////////////////////////////
  // LED and converter outputs
  logic conv_d, video_d, flash_d;
  always_comb begin
    // RULE16: force bit keeps converter regulating
    // RULE15: mode 11 regulates voltage
    conv_d  = ctrl_q.fvr || (ctrl_q.mode == fvm_pkg::MODE_VOLT);
    // RULE4: mode 01 steady video light
    // RULE8: strobes drive LEDs in mode 10
    video_d = (ctrl_q.mode == fvm_pkg::MODE_VIDEO) ||
              (strobe_mode && strobe_select_input && strobe_trigger_input);
    flash_d = strobe_mode && (fl_q != fvm_pkg::FL_IDLE) && ft_running;
    // RULE17: shutdown and mode 11 keep both LEDs off
    if (ctrl_q.mode == fvm_pkg::MODE_SHDN || ctrl_q.mode == fvm_pkg::MODE_VOLT) begin
      video_d = 1'b0;
      flash_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_on              <= 1'b0;
      video_on              <= 1'b0;
      conv_vreg             <= 1'b0;
      video_current_setting <= fvm_pkg::VCUR_RST;
      vout_target_mv        <= 13'h0000;
    end else begin
      flash_on              <= flash_d;
      video_on              <= video_d;
      conv_vreg             <= conv_d;
      video_current_setting <= ctrl_q.vcur;
      // RULE23: linear code to voltage
      vout_target_mv        <= 13'(fvm_pkg::VOUT_MIN_MV +
                               fvm_pkg::VOUT_STEP_MV * int'(output_voltage_code));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power good and status pin
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      output_in_regulation <= 1'b0;
    else
      // RULE18: gated by voltage mode
      // RULE21: window from analog comparator
      // RULE22: not good while returning energy
      output_in_regulation <= conv_d && vout_in_window && !vout_falling;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_out <= 1'b0;
      status_oe  <= 1'b1;
    end else if (!ctrl_q.ptype) begin
      // RULE19: push-pull shutdown drives low
      // RULE20: push-pull follows flag
      status_out <= conv_d && output_in_regulation;
      status_oe  <= 1'b1;
    end else begin
      // RULE20: open-drain pulls low when good
      status_out <= 1'b0;
      status_oe  <= conv_d && output_in_regulation;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_mode01_no_flash;
    @(posedge clk) disable iff (sys_rst)
    (ctrl_q.mode == fvm_pkg::MODE_VIDEO) ##1 (ctrl_q.mode == fvm_pkg::MODE_VIDEO) |-> !flash_on;
  endproperty
  a_mode01_no_flash: assert property (p_mode01_no_flash) // RULE4
    else $error("flash on in video mode");

  property p_shutdown_off;
    @(posedge clk) disable iff (sys_rst)
    (ctrl_q.mode == fvm_pkg::MODE_SHDN && !ctrl_q.fvr) |=> (!conv_vreg && !video_on && !flash_on);
  endproperty
  a_shutdown_off: assert property (p_shutdown_off) // RULE17
    else $error("outputs on in shutdown");

  property p_pg_gated;
    @(posedge clk) disable iff (sys_rst)
    (ctrl_q.mode != fvm_pkg::MODE_VOLT && !ctrl_q.fvr) |=> !output_in_regulation;
  endproperty
  a_pg_gated: assert property (p_pg_gated) // RULE18
    else $error("power good outside voltage mode");

  property p_expiry_clears_sfs;
    @(posedge clk) disable iff (sys_rst)
    flash_expire |=> !ctrl_q.sfs && expiry_flag;
  endproperty
  a_expiry_clears_sfs: assert property (p_expiry_clears_sfs) // RULE14
    else $error("start bit not cleared at expiry");

  property p_edge_holds;
    @(posedge clk) disable iff (sys_rst)
    (fl_q == fvm_pkg::FL_EDGE && strobe_mode && !flash_expire) ##1 strobe_mode
      |-> (fl_q == fvm_pkg::FL_EDGE);
  endproperty
  a_edge_holds: assert property (p_edge_holds) // RULE13
    else $error("edge flash ended early");

  property p_level_stop;
    @(posedge clk) disable iff (sys_rst)
    level_stop |=> (fl_q == fvm_pkg::FL_IDLE) ##1 !flash_on;
  endproperty
  a_level_stop: assert property (p_level_stop) // RULE11
    else $error("level flash not stopped");

  property p_wd_off_sel;
    @(posedge clk) disable iff (sys_rst)
    strobe_select_input |=> !wd_tripped_q;
  endproperty
  a_wd_off_sel: assert property (p_wd_off_sel) // RULE6
    else $error("watchdog tripped with select high");

  property p_wd_shutdown;
    @(posedge clk) disable iff (sys_rst)
    (wd_tripped_q && !mode_wr) |=> (ctrl_q.mode == fvm_pkg::MODE_SHDN);
  endproperty
  a_wd_shutdown: assert property (p_wd_shutdown) // RULE5
    else $error("no shutdown at watchdog timeout");

  property p_od_pin;
    @(posedge clk) disable iff (sys_rst)
    (ctrl_q.ptype && $past(ctrl_q.ptype)) |-> (status_out == 1'b0);
  endproperty
  a_od_pin: assert property (p_od_pin) // RULE20
    else $error("open-drain pin driven high");

  property p_level_start;
    @(posedge clk) disable iff (sys_rst)
    start_level |=> (fl_q == fvm_pkg::FL_LEVEL) && ft_running;
  endproperty
  a_level_start: assert property (p_level_start) // RULE3
    else $error("level flash timer not started");

endmodule // fvm_ctrl
`default_nettype wire

//--- bench/fvm_host.sv
// Camera engine model that drives the strobe select and trigger lines
`timescale 1ns/1ns
`default_nettype none
module fvm_host (
  input  wire logic       clk,                  // System clock
  input  wire logic       sys_rst,              // Async reset, active high
  input  wire logic       go,                   // Start one trigger pulse
  input  wire logic [9:0] len,                  // Pulse length in cycles
  input  wire logic       sel,                  // Requested select level
  output logic            strobe_trigger_input, // Trigger line
  output logic            strobe_select_input   // Select line
);
  logic [9:0] cnt_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q                <= 10'h000;
      strobe_trigger_input <= 1'b0;
      strobe_select_input  <= 1'b0;
    end else begin
      strobe_select_input  <= sel;
      cnt_q                <= go ? len : (cnt_q != 10'h000 ? cnt_q - 10'h001 : cnt_q);
      // Push-pull lines: trigger returns low between pulses
      strobe_trigger_input <= go || (cnt_q > 10'h001);
    end
  end
endmodule // fvm_host
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the flash and video-light mode controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
  localparam longint WD = 200;
  logic clk, sys_rst, psel, penable, pwrite, win, fall, go, sel;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, err, flash_on, video_on, conv_vreg, status_out, status_oe;
  logic [2:0] vcs;
  logic [12:0] vmv;
  logic [9:0] len;
  wire logic trig, sel_in;
  int miscompares, tests_run, c, d, k;

  fvm_host u_host (.clk(clk), .sys_rst(sys_rst), .go(go), .len(len), .sel(sel),
    .strobe_trigger_input(trig), .strobe_select_input(sel_in));
  fvm_ctrl #(.WD_CYC(WD), .FT_SHORT(10), .FT_LONG(40)) DUT (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .strobe_trigger_input(trig),
    .strobe_select_input(sel_in), .vout_in_window(win), .vout_falling(fall),
    .flash_on(flash_on), .video_on(video_on), .video_current_setting(vcs),
    .conv_vreg(conv_vreg), .vout_target_mv(vmv), .status_out(status_out),
    .status_oe(status_oe));

  always #20 clk = ~clk;

  function automatic logic [31:0] cw(input logic [1:0] m, input logic f, t, s, p,
                                     input logic [2:0] v);
    return {21'h0, v, 2'h0, p, s, t, f, m};
  endfunction
  function automatic logic near(input int got, input int e);
    return (got >= e - 3) && (got <= e + 3);
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= dt; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    // Response and read data are taken at the edge that sees pready high
    do @(posedge clk); while (pready !== 1'b1);
    err = pslverr;
    r = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic strobe(input logic s, input logic [9:0] l);
    @(posedge clk);
    go <= 1'b1; sel <= s; len <= l;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic meas(output int cnt);
    int n;
    n = 0;
    cnt = 0;
    while (flash_on !== 1'b1 && n < 100) begin @(negedge clk); n++; end
    while (flash_on === 1'b1 && cnt < 2000) begin @(negedge clk); cnt++; end
  endtask
  task automatic sett(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #(40 * 30000);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    clk = 0; sys_rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    win = 0; fall = 0; go = 0; sel = 0; len = 0;
    miscompares = 0; tests_run = 0;
    void'($urandom(32'h625A));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    sett(1);
    `CHK({status_oe, status_out}, 2'b10)
    for (k = 0; k < 3; k++) begin
      apb(0, 8'(4 * k), 0);
      `CHK(r, 32'h0)
    end
    apb(1, 8'h40, 32'hFF);
    `CHK(err, 1'b1)
    // Voltage mode with random codes
    for (k = 0; k < 4; k++) begin
      d = $urandom_range(15);
      apb(1, 8'h08, d);
      apb(1, 8'h00, cw(2'h3, 0, 0, 0, 0, 3'h0));
      sett(3);
      `CHK(vmv, 13'(3825 + 125 * d))
      `CHK({conv_vreg, flash_on, video_on}, 3'b100)
    end
    @(posedge clk) win <= 1'b1;
    sett(3);
    `CHK({status_oe, status_out}, 2'b11)
    @(posedge clk) fall <= 1'b1;
    sett(3);
    `CHK(status_out, 1'b0)
    @(posedge clk) fall <= 1'b0;
    apb(1, 8'h00, cw(2'h3, 0, 0, 0, 1, 3'h0));
    sett(3);
    `CHK({status_oe, status_out}, 2'b10)
    @(posedge clk) win <= 1'b0;
    sett(3);
    `CHK(status_oe, 1'b0)
    @(posedge clk) win <= 1'b1;
    apb(1, 8'h00, cw(2'h0, 0, 0, 0, 1, 3'h0));
    sett(3);
    `CHK({status_oe, conv_vreg}, 2'b00)
    apb(1, 8'h00, cw(2'h0, 1, 0, 0, 0, 3'h0));
    sett(3);
    `CHK({conv_vreg, status_out}, 2'b11)
    // Video light ignores strobes; watchdog trips without refresh
    d = $urandom_range(7);
    apb(1, 8'h00, cw(2'h1, 0, 1, 1, 0, 3'(d)));
    strobe(0, 10'd20);
    meas(c);
    `CHK(c, 0)
    `CHK({video_on, vcs}, {1'b1, 3'(d)})
    sett(WD + 20);
    `CHK(video_on, 1'b0)
    apb(0, 8'h00, 0);
    `CHK(r[1:0], 2'h0)
    apb(1, 8'h00, cw(2'h1, 0, 0, 0, 0, 3'h0));
    sett(WD - 60);
    apb(1, 8'h00, cw(2'h1, 0, 0, 0, 0, 3'h0));
    sett(WD - 60);
    `CHK(video_on, 1'b1)
    @(posedge clk) sel <= 1'b1;
    sett(2 * WD);
    `CHK(video_on, 1'b1)
    // Flash mode, select high fires video light
    apb(1, 8'h00, cw(2'h2, 0, 1, 0, 0, 3'h0));
    strobe(1, 10'd20);
    sett(6);
    `CHK({video_on, flash_on}, 2'b10)
    sett(30);
    // Edge flash with a retrigger mid-pulse
    d = $urandom_range(2, 7);
    k = $urandom_range(1);
    apb(1, 8'h04, (k << 3) | d);
    strobe(0, 10'd3);
    fork
      meas(c);
      begin repeat (15) @(posedge clk); strobe(0, 10'd3); end
    join
    `CHK(near(c, (d + 1) * (k ? 40 : 10)), 1'b1)
    // Software start, then the start bit self-clears
    apb(1, 8'h04, 32'h1);
    apb(1, 8'h00, cw(2'h2, 0, 0, 1, 0, 3'h0));
    meas(c);
    `CHK(near(c, 20), 1'b1)
    apb(0, 8'h00, 0);
    `CHK(r[4], 1'b0)
    apb(0, 8'h0C, 0);
    `CHK(r[0], 1'b1)
    apb(1, 8'h0C, 32'h1);
    apb(0, 8'h0C, 0);
    `CHK(r[0], 1'b0)
    // Level trigger: follows strobe, capped by the timer
    apb(1, 8'h00, cw(2'h2, 0, 0, 0, 0, 3'h0));
    strobe(0, 10'd8);
    meas(c);
    `CHK(near(c, 8), 1'b1)
    strobe(0, 10'd100);
    meas(c);
    `CHK(near(c, 20), 1'b1)
    sett(100);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
